// [mbsx_core.sv]
/*
 * Request interpreter of the slave: collects a request frame, checks it, looks up the
 * parameter, writes or reads it and sends a normal or exception reply with its frame check.
 * Assumes a framing layer that strobes received bytes and marks frame end in a later cycle,
 * a parameter table answering lookup_addr_out one cycle later, and a byte transmitter.
 */
`timescale 1ns/100ps
module mbsx_core (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [7:0] slave_addr_in,
    input wire logic [7:0] rx_byte_in,
    input wire logic rx_valid_in,
    input wire logic rx_end_in,
    input wire logic drive_running_in,
    input wire logic drive_fault_in,
    input wire logic [15:0] user_password_setting_in,
    input wire mbsx_pkg::mbsx_attr_s attr_in,
    input wire logic [15:0] rd_data_in,
    input wire logic tx_ready_in,
    output logic [15:0] lookup_addr_out,
    output logic [7:0] tx_byte_out,
    output logic tx_valid_out,
    output logic tx_last_out,
    output mbsx_pkg::mbsx_wr_s wr_out,
    output logic unlocked_out
);
    mbsx_pkg::mbsx_state_e state_reg, state_next;
    logic [7:0] rx_buf_reg [8];
    logic [7:0] rx_buf_next [8];
    logic [3:0] rx_cnt_reg, rx_cnt_next;
    logic [15:0] rx_crc_reg, rx_crc_next, rx_crc_step;
    logic [7:0] tx_buf_reg [6];
    logic [7:0] tx_buf_next [6];
    logic [3:0] tx_len_reg, tx_len_next, tx_idx_reg, tx_idx_next;
    logic [15:0] tx_crc_reg, tx_crc_next, tx_crc_step;
    logic [7:0] tx_byte_reg, tx_byte_next, tx_src;
    logic tx_valid_reg, tx_valid_next, tx_last_reg, tx_last_next;
    logic [15:0] lookup_addr_reg, lookup_addr_next;
    mbsx_pkg::mbsx_wr_s wr_reg, wr_next;
    logic unlocked_reg, unlocked_next;
    logic [7:0] err_reg, err_next, err_calc;
    logic [7:0] func;
    logic [15:0] req_addr, req_data;
    logic locked, fire;
    default clocking mbsx_cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // check over received and sent bytes
    mbsx_crc_step u_rx_crc (.crc_in(rx_crc_reg), .byte_in(rx_byte_in), .crc_out(rx_crc_step));
    mbsx_crc_step u_tx_crc (.crc_in(tx_crc_reg), .byte_in(tx_src), .crc_out(tx_crc_step));

    assign func = rx_buf_reg[1];
    assign req_addr = {rx_buf_reg[2], rx_buf_reg[3]};
    assign req_data = {rx_buf_reg[4], rx_buf_reg[5]};
    assign locked = (user_password_setting_in != mbsx_pkg::NO_PASSWORD) && !unlocked_reg;
    assign fire = tx_valid_reg && tx_ready_in;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Checks are ordered so that the cheapest, frame-level faults are reported first.
    always_comb begin
        err_calc = mbsx_pkg::ERR_NONE;
        if (rx_cnt_reg != mbsx_pkg::REQ_LEN || rx_crc_reg != mbsx_pkg::CRC_RESIDUE) begin
            err_calc = mbsx_pkg::ERR_FRAME;
        end else if (func != mbsx_pkg::FC_READ && func != mbsx_pkg::FC_WRITE) begin
            err_calc = mbsx_pkg::ERR_CMD;
        end else if (drive_fault_in) begin
            err_calc = mbsx_pkg::ERR_CMD;
        end else if (locked && !(func == mbsx_pkg::FC_WRITE
                                 && req_addr == mbsx_pkg::PWD_VERIFY_ADDR)) begin
            err_calc = mbsx_pkg::ERR_LOCKED;
        end else if (func == mbsx_pkg::FC_WRITE && req_addr == mbsx_pkg::PWD_VERIFY_ADDR) begin
            if (req_data != user_password_setting_in) begin
                err_calc = mbsx_pkg::ERR_PWD;
            end
        end else if (!attr_in.valid) begin
            err_calc = mbsx_pkg::ERR_ADDR;
        end else if (func == mbsx_pkg::FC_READ) begin
            if (req_data == 16'h0000) begin
                err_calc = mbsx_pkg::ERR_DATA;
            end else if (req_data > mbsx_pkg::READ_QTY_MAX) begin
                err_calc = mbsx_pkg::ERR_ADDR;
            end
        end else if (attr_in.read_only) begin
            err_calc = mbsx_pkg::ERR_RDONLY;
        end else if (attr_in.run_locked && drive_running_in) begin
            err_calc = mbsx_pkg::ERR_RUNNING;
        end else if (req_data < attr_in.min_val || req_data > attr_in.max_val
                     || attr_in.duplicate) begin
            err_calc = mbsx_pkg::ERR_OPER;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_next = state_reg;
        rx_buf_next = rx_buf_reg;
        rx_cnt_next = rx_cnt_reg;
        rx_crc_next = rx_crc_reg;
        tx_buf_next = tx_buf_reg;
        tx_len_next = tx_len_reg;
        tx_idx_next = tx_idx_reg;
        tx_crc_next = tx_crc_reg;
        tx_byte_next = tx_byte_reg;
        tx_valid_next = tx_valid_reg;
        tx_last_next = tx_last_reg;
        lookup_addr_next = lookup_addr_reg;
        wr_next = wr_reg;
        wr_next.strobe = 1'b0;
        unlocked_next = unlocked_reg;
        err_next = err_reg;
        tx_src = 8'h00;
        if (tx_idx_reg < tx_len_reg) begin
            tx_src = tx_buf_reg[tx_idx_reg[2:0]];
        end
        // A cleared password leaves nothing to unlock, so a later one starts locked.
        if (user_password_setting_in == mbsx_pkg::NO_PASSWORD) begin
            unlocked_next = 1'b0;
        end
        case (state_reg)
            mbsx_pkg::ST_RX: begin
                if (rx_valid_in) begin
                    if (rx_cnt_reg < mbsx_pkg::REQ_LEN) begin
                        rx_buf_next[rx_cnt_reg[2:0]] = rx_byte_in;
                    end
                    if (rx_cnt_reg != mbsx_pkg::RX_CNT_OVF) begin
                        rx_cnt_next = rx_cnt_reg + 4'h1;
                    end
                    rx_crc_next = rx_crc_step;
                end else if (rx_end_in) begin
                    // Frames for other stations, and broadcasts, get no answer at all.
                    if (rx_cnt_reg != 4'h0 && rx_buf_reg[0] == slave_addr_in) begin
                        lookup_addr_next = req_addr;
                        state_next = mbsx_pkg::ST_LOOK;
                    end else begin
                        rx_cnt_next = 4'h0;
                        rx_crc_next = mbsx_pkg::CRC_INIT;
                    end
                end
            end
            mbsx_pkg::ST_LOOK: state_next = mbsx_pkg::ST_DECIDE;
            mbsx_pkg::ST_DECIDE: begin
                err_next = err_calc;
                tx_buf_next[0] = rx_buf_reg[0];
                tx_idx_next = 4'h0;
                tx_crc_next = mbsx_pkg::CRC_INIT;
                if (err_calc != mbsx_pkg::ERR_NONE) begin
                    tx_buf_next[1] = func | mbsx_pkg::FC_EXC_BIT;
                    tx_buf_next[2] = err_calc;
                    tx_len_next = mbsx_pkg::EXC_LEN;
                end else if (func == mbsx_pkg::FC_READ) begin
                    tx_buf_next[1] = func;
                    tx_buf_next[2] = mbsx_pkg::READ_BYTE_COUNT;
                    tx_buf_next[3] = rd_data_in[15:8];
                    tx_buf_next[4] = rd_data_in[7:0];
                    tx_len_next = mbsx_pkg::READ_REPLY_LEN;
                end else begin
                    for (int i = 1; i < 6; i++) begin
                        tx_buf_next[i] = rx_buf_reg[i];
                    end
                    tx_len_next = mbsx_pkg::WRITE_REPLY_LEN;
                    if (req_addr == mbsx_pkg::PWD_VERIFY_ADDR) begin
                        unlocked_next = 1'b1;
                    end else begin
                        wr_next.strobe = 1'b1;
                        wr_next.addr = req_addr;
                        wr_next.data = req_data;
                        // scale is ten to the decimals
                        wr_next.scale = mbsx_pkg::SCALE_BY_DEC[attr_in.decimals];
                    end
                end
                state_next = mbsx_pkg::ST_SEND;
            end
            mbsx_pkg::ST_SEND: begin
                if (!tx_valid_reg || fire) begin
                    if (tx_idx_reg < tx_len_reg) begin
                        tx_byte_next = tx_src;
                        tx_crc_next = tx_crc_step;
                    end else begin
                        tx_byte_next = (tx_idx_reg == tx_len_reg) ? tx_crc_reg[7:0]
                                                                  : tx_crc_reg[15:8];
                    end
                    if (tx_idx_reg < tx_len_reg + 4'h2) begin
                        tx_valid_next = 1'b1;
                        tx_last_next = (tx_idx_reg == tx_len_reg + 4'h1);
                        tx_idx_next = tx_idx_reg + 4'h1;
                    end else begin
                        tx_valid_next = 1'b0;
                        tx_last_next = 1'b0;
                        rx_cnt_next = 4'h0;
                        rx_crc_next = mbsx_pkg::CRC_INIT;
                        state_next = mbsx_pkg::ST_RX;
                    end
                end
            end
            default: state_next = mbsx_pkg::ST_RX;
        endcase
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= mbsx_pkg::ST_RX;
            rx_buf_reg <= '{default: 8'h00};
            rx_cnt_reg <= 4'h0;
            rx_crc_reg <= mbsx_pkg::CRC_INIT;
            tx_buf_reg <= '{default: 8'h00};
            tx_len_reg <= 4'h0;
            tx_idx_reg <= 4'h0;
            tx_crc_reg <= mbsx_pkg::CRC_INIT;
            tx_byte_reg <= 8'h00;
            tx_valid_reg <= 1'b0;
            tx_last_reg <= 1'b0;
            lookup_addr_reg <= 16'h0000;
            wr_reg <= '0;
            unlocked_reg <= 1'b0;
            err_reg <= mbsx_pkg::ERR_NONE;
        end else begin
            state_reg <= state_next;
            rx_buf_reg <= rx_buf_next;
            rx_cnt_reg <= rx_cnt_next;
            rx_crc_reg <= rx_crc_next;
            tx_buf_reg <= tx_buf_next;
            tx_len_reg <= tx_len_next;
            tx_idx_reg <= tx_idx_next;
            tx_crc_reg <= tx_crc_next;
            tx_byte_reg <= tx_byte_next;
            tx_valid_reg <= tx_valid_next;
            tx_last_reg <= tx_last_next;
            lookup_addr_reg <= lookup_addr_next;
            wr_reg <= wr_next;
            unlocked_reg <= unlocked_next;
            err_reg <= err_next;
        end
    end
    assign lookup_addr_out = lookup_addr_reg;
    assign tx_byte_out = tx_byte_reg;
    assign tx_valid_out = tx_valid_reg;
    assign tx_last_out = tx_last_reg;
    assign wr_out = wr_reg;
    assign unlocked_out = unlocked_reg;

    ////////////////////////////////////////////////////////////////////////////////////////////
    logic [3:0] shown_idx;
    logic frame_ok;
    assign shown_idx = tx_idx_reg - 4'h1;
    assign frame_ok = rx_cnt_reg == mbsx_pkg::REQ_LEN && rx_crc_reg == mbsx_pkg::CRC_RESIDUE;
    sequence s_req_taken;
        state_reg == mbsx_pkg::ST_RX && !rx_valid_in && rx_end_in
            && rx_cnt_reg != 4'h0 && rx_buf_reg[0] == slave_addr_in;
    endsequence
    sequence s_reply_starts;
        state_reg == mbsx_pkg::ST_DECIDE ##1 state_reg == mbsx_pkg::ST_SEND ##1 tx_valid_reg;
    endsequence
    property p_reply_follows;
        s_req_taken |=> ##1 s_reply_starts;
    endproperty
    a_reply_follows: assert property (p_reply_follows) else $error("reply not started");
    property p_exc_code;
        tx_valid_reg && err_reg != 8'h00 && shown_idx == 4'h1 |-> tx_byte_out == (func | 8'h80);
    endproperty
    a_exc_code: assert property (p_exc_code) else $error("exception top bit missing");
    property p_exc_len;
        state_reg == mbsx_pkg::ST_SEND && err_reg != 8'h00 |-> tx_len_reg == 4'h3;
    endproperty
    a_exc_len: assert property (p_exc_len) else $error("exception length wrong");
    property p_ok_code;
        tx_valid_reg && err_reg == 8'h00 && shown_idx == 4'h1 |-> tx_byte_out == func;
    endproperty
    a_ok_code: assert property (p_ok_code) else $error("normal reply code changed");
    property p_echo;
        tx_valid_reg && err_reg == 8'h00 && func == 8'h06 && shown_idx < 4'h6
            |-> tx_byte_out == rx_buf_reg[shown_idx[2:0]];
    endproperty
    a_echo: assert property (p_echo) else $error("write reply not an echo");
    property p_frame_err;
        state_reg == mbsx_pkg::ST_DECIDE && rx_cnt_reg != 4'h8 |=> err_reg == 8'h06;
    endproperty
    a_frame_err: assert property (p_frame_err) else $error("bad length not code 06");
    property p_bad_func;
        state_reg == mbsx_pkg::ST_DECIDE && frame_ok && func != 8'h03 && func != 8'h06
            |=> err_reg == 8'h01;
    endproperty
    a_bad_func: assert property (p_bad_func) else $error("unsupported code not 01");
    property p_locked;
        state_reg == mbsx_pkg::ST_DECIDE && frame_ok && func == 8'h03
            && !drive_fault_in && locked |=> err_reg == 8'h09;
    endproperty
    a_locked: assert property (p_locked) else $error("locked read not code 09");
    property p_wr_clean;
        wr_reg.strobe |-> err_reg == 8'h00 && !$past(attr_in.read_only)
            && $past(state_reg) == mbsx_pkg::ST_DECIDE;
    endproperty
    a_wr_clean: assert property (p_wr_clean) else $error("write applied despite fault");
    property p_crc_tail;
        tx_valid_reg && tx_last_reg |-> tx_byte_out == tx_crc_reg[15:8];
    endproperty
    a_crc_tail: assert property (p_crc_tail) else $error("last byte not check high");
endmodule // mbsx_core

// [mbsx_crc_step.sv]
/*
 * One byte step of the 16-bit reflected frame check, purely combinational.
 * Assumes the caller holds the running value in its own register.
 */
`timescale 1ns/100ps
module mbsx_crc_step (
    input wire logic [15:0] crc_in,
    input wire logic [7:0] byte_in,
    output logic [15:0] crc_out
);
    logic [15:0] acc;

    always_comb begin
        acc = crc_in ^ {8'h00, byte_in};
        for (int i = 0; i < 8; i++) begin
            if (acc[0]) begin
                acc = (acc >> 1) ^ mbsx_pkg::CRC_POLY;
            end else begin
                acc = acc >> 1;
            end
        end
        crc_out = acc;
    end
endmodule // mbsx_crc_step

// [mbsx_master_model.sv]
/*
 * Behavioural master for the slave: sends request frames with their frame check and
 * collects reply bytes. Assumes one clock shared with the slave and a caller that waits
 * for done before starting the next frame.
 */
`timescale 1ns/100ps
module mbsx_master_model (
    input wire logic clk_in,
    input wire logic [7:0] tx_byte_in,
    input wire logic tx_valid_in,
    input wire logic tx_last_in,
    input wire logic slow_in,
    output logic [7:0] rx_byte_out,
    output logic rx_valid_out,
    output logic rx_end_out,
    output logic tx_ready_out
);
    logic [7:0] rep [16];
    int rep_n = 0;
    logic done = 1'b0;

    initial begin
        rx_byte_out = 8'h00;
        rx_valid_out = 1'b0;
        rx_end_out = 1'b0;
        tx_ready_out = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // reflected check
    function automatic logic [15:0] crc16(input logic [7:0] b [8], input int n);
        logic [15:0] c;
        c = 16'hFFFF;
        for (int i = 0; i < n; i++) begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++) begin
                c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
            end
        end
        return c;
    endfunction

    task automatic send(input logic [7:0] f [8], input int n, input bit bad);
        logic [15:0] c;
        c = crc16(f, n);
        rep_n = 0;
        done = 1'b0;
        for (int i = 0; i < n + 2; i++) begin
            @(posedge clk_in);
            rx_valid_out <= 1'b1;
            rx_byte_out <= (i < n) ? f[i] : ((i == n) ? (c[7:0] ^ {7'h00, bad}) : c[15:8]);
        end
        @(posedge clk_in);
        rx_valid_out <= 1'b0;
        rx_byte_out <= ~rx_byte_out;
        rx_end_out <= 1'b1;
        @(posedge clk_in);
        rx_end_out <= 1'b0;
    endtask

    // A slow master accepts only every other cycle, so the slave must hold its byte.
    always @(posedge clk_in) begin
        tx_ready_out <= slow_in ? ~tx_ready_out : 1'b1;
        if (tx_valid_in && tx_ready_out && rep_n < 16) begin
            rep[rep_n] <= tx_byte_in;
            rep_n <= rep_n + 1;
            done <= tx_last_in;
        end
    end
endmodule // mbsx_master_model

// [mbsx_pkg.sv]
/*
 * Shared constants and carrier types of the serial register-access slave: function codes,
 * exception codes, frame sizes, CRC constants and the parameter attribute and write structs.
 * Assumes the framing layer outside delivers whole frames byte by byte with an end marker.
 */
package mbsx_pkg;

    ////////////////////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] FC_READ = 8'h03;
    localparam logic [7:0] FC_WRITE = 8'h06;
    localparam logic [7:0] FC_EXC_BIT = 8'h80;

    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_CMD = 8'h01;
    localparam logic [7:0] ERR_ADDR = 8'h02;
    localparam logic [7:0] ERR_DATA = 8'h03;
    localparam logic [7:0] ERR_OPER = 8'h04;
    localparam logic [7:0] ERR_PWD = 8'h05;
    localparam logic [7:0] ERR_FRAME = 8'h06;
    localparam logic [7:0] ERR_RDONLY = 8'h07;
    localparam logic [7:0] ERR_RUNNING = 8'h08;
    localparam logic [7:0] ERR_LOCKED = 8'h09;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Every supported request is address, function, two words and CRC.
    localparam logic [3:0] REQ_LEN = 4'h8;
    localparam logic [3:0] RX_CNT_OVF = 4'h9;
    localparam logic [3:0] EXC_LEN = 4'h3;
    localparam logic [3:0] READ_REPLY_LEN = 4'h5;
    localparam logic [3:0] WRITE_REPLY_LEN = 4'h6;
    localparam logic [7:0] READ_BYTE_COUNT = 8'h02;
    localparam logic [15:0] READ_QTY_MAX = 16'h0001;
    localparam logic [15:0] PWD_VERIFY_ADDR = 16'h1F00;
    localparam logic [15:0] NO_PASSWORD = 16'h0000;

    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam logic [15:0] CRC_RESIDUE = 16'h0000;

    // Link integer equals value times ten to the number of decimals.
    localparam logic [15:0] SCALE_BY_DEC [4] = '{16'h0001, 16'h000A, 16'h0064, 16'h03E8};

    ////////////////////////////////////////////////////////////////////////////////////////////
    typedef enum {ST_RX, ST_LOOK, ST_DECIDE, ST_SEND} mbsx_state_e;

    typedef struct packed {
        logic valid;
        logic read_only;
        logic run_locked;
        logic duplicate;
        logic [1:0] decimals;
        logic [15:0] min_val;
        logic [15:0] max_val;
    } mbsx_attr_s;

    typedef struct packed {
        logic strobe;
        logic [15:0] addr;
        logic [15:0] data;
        logic [15:0] scale;
    } mbsx_wr_s;

endpackage

// [modbus_slave_scale_and_exceptions_bench.sv]
/*
 * Self-checking bench of the request interpreter with a small parameter table.
 * Assumes the master model answers every reply byte and sends whole frames.
 */
`timescale 1ns/100ps
module modbus_slave_scale_and_exceptions_bench;
    logic clk = 1'b0, rst = 1'b1, slow = 1'b0, run_st = 1'b0, fault = 1'b0;
    logic [15:0] pwd = 16'h0000, lk;
    logic [7:0] txb, rxb;
    logic txv, txl, txr, rxv, rxe, unl;
    mbsx_pkg::mbsx_wr_s wr;
    mbsx_pkg::mbsx_attr_s attr;
    int bad_count = 0, samples_checked = 0, cycles = 0, wr_cnt = 0, req_len = 6;

    function automatic mbsx_pkg::mbsx_attr_s attr_of(input logic [15:0] a);
        case (a)
            16'h0114: return '{1'b1, 1'b0, 1'b0, 1'b0, 2'h1, 16'h0000, 16'h8CA0};
            16'h0001: return '{1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 16'h0000, 16'h0002};
            16'h0005: return '{1'b1, 1'b0, 1'b0, 1'b1, 2'h0, 16'h0000, 16'h0009};
            16'h0003: return '{1'b1, 1'b0, 1'b1, 1'b0, 2'h2, 16'h0000, 16'hF618};
            16'h2103: return '{1'b1, 1'b1, 1'b0, 1'b0, 2'h0, 16'h0000, 16'hFFFF};
            default: return '0;
        endcase
    endfunction
    assign attr = attr_of(lk);

    mbsx_core dut (.sys_clk_in(clk), .rst_in(rst), .slave_addr_in(8'h01), .rx_byte_in(rxb),
        .rx_valid_in(rxv), .rx_end_in(rxe), .drive_running_in(run_st), .drive_fault_in(fault),
        .user_password_setting_in(pwd), .attr_in(attr), .rd_data_in(lk ^ 16'hA5C3),
        .tx_ready_in(txr), .lookup_addr_out(lk), .tx_byte_out(txb), .tx_valid_out(txv),
        .tx_last_out(txl), .wr_out(wr), .unlocked_out(unl));
    mbsx_master_model m (.clk_in(clk), .tx_byte_in(txb), .tx_valid_in(txv), .tx_last_in(txl),
        .slow_in(slow), .rx_byte_out(rxb), .rx_valid_out(rxv), .rx_end_out(rxe),
        .tx_ready_out(txr));

    ////////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        wr_cnt <= wr_cnt + ((wr.strobe === 1'b1) ? 1 : 0);
        if (cycles == 6000) begin
            bad_count++;
            print_verdict();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // A code of FF means no reply at all is expected.
    task automatic run(input logic [7:0] sa, input logic [7:0] fc, input logic [15:0] a,
                       input logic [15:0] d, input bit bad, input logic [7:0] code);
        logic [7:0] f [8];
        logic [7:0] e [8];
        logic [15:0] c, rd;
        int en;
        f = '{sa, fc, a[15:8], a[7:0], d[15:8], d[7:0], 8'h00, 8'h00};
        rd = a ^ 16'hA5C3;
        e = f;
        en = (code == 8'hFF) ? -2 : 6;
        if (code != 8'h00 && code != 8'hFF) begin
            e = '{sa, fc | 8'h80, code, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
            en = 3;
        end else if (code == 8'h00 && fc == 8'h03) begin
            e = '{sa, 8'h03, 8'h02, rd[15:8], rd[7:0], 8'h00, 8'h00, 8'h00};
            en = 5;
        end
        m.send(f, req_len, bad);
        for (int i = 0; i < 60 && m.done !== 1'b1; i++) @(posedge clk);
        c = m.crc16(e, en);
        check(16'(m.rep_n), 16'(en + 2));
        for (int i = 0; i < en; i++) check({8'h00, m.rep[i]}, {8'h00, e[i]});
        if (en > 0) check({m.rep[en + 1], m.rep[en]}, c);
    endtask

    ////////////////////////////////////////////////////////////////////////////////////
    task automatic t_normal();
        int w0;
        run(8'h01, 8'h03, 16'h0114, 16'h0001, 1'b0, 8'h00);
        w0 = wr_cnt;
        // Delay 5.0 with one decimal goes out as 50.
        run(8'h01, 8'h06, 16'h0114, 16'h0032, 1'b0, 8'h00);
        check({m.rep[7], m.rep[6]}, 16'hE749);
        check(16'(wr_cnt - w0), 16'h0001);
        check(wr.addr, 16'h0114);
        check(wr.data, 16'h0032);
        check(wr.scale, 16'h000A);
        slow <= 1'b1;
        run(8'h01, 8'h03, 16'h0003, 16'h0001, 1'b0, 8'h00);
        slow <= 1'b0;
        run(8'h02, 8'h03, 16'h0114, 16'h0001, 1'b0, 8'hFF);
    endtask

    task automatic t_errors();
        run(8'h01, 8'h06, 16'h0001, 16'h0003, 1'b0, 8'h04);
        check({m.rep[4], m.rep[3]}, 16'hA343);
        run(8'h01, 8'h06, 16'h0005, 16'h0001, 1'b0, 8'h04);
        run(8'h01, 8'h10, 16'h0001, 16'h0001, 1'b0, 8'h01);
        run(8'h01, 8'h03, 16'h0114, 16'h0000, 1'b0, 8'h03);
        run(8'h01, 8'h03, 16'h0114, 16'h0002, 1'b0, 8'h02);
        run(8'h01, 8'h03, 16'h4444, 16'h0001, 1'b0, 8'h02);
        run(8'h01, 8'h06, 16'h2103, 16'h0001, 1'b0, 8'h07);
        run(8'h01, 8'h03, 16'h0114, 16'h0001, 1'b1, 8'h06);
        // A request cut to six bytes keeps a good check but has the wrong length.
        req_len = 4;
        run(8'h01, 8'h03, 16'h0114, 16'h0001, 1'b0, 8'h06);
        req_len = 6;
    endtask

    task automatic t_state();
        run_st <= 1'b1;
        run(8'h01, 8'h06, 16'h0003, 16'h2710, 1'b0, 8'h08);
        run(8'h01, 8'h06, 16'h0114, 16'h0032, 1'b0, 8'h00);
        run_st <= 1'b0;
        // A value of 100.00 with two decimals goes out as 10000.
        run(8'h01, 8'h06, 16'h0003, 16'h2710, 1'b0, 8'h00);
        check(wr.addr, 16'h0003);
        check(wr.scale, 16'h0064);
        fault <= 1'b1;
        run(8'h01, 8'h03, 16'h0114, 16'h0001, 1'b0, 8'h01);
        fault <= 1'b0;
        run(8'h01, 8'h03, 16'h0114, 16'h0001, 1'b0, 8'h00);
    endtask

    task automatic t_password();
        pwd <= 16'h1234;
        run(8'h01, 8'h03, 16'h0114, 16'h0001, 1'b0, 8'h09);
        run(8'h01, 8'h06, 16'h1F00, 16'h1111, 1'b0, 8'h05);
        run(8'h01, 8'h06, 16'h1F00, 16'h1234, 1'b0, 8'h00);
        check({15'h0000, unl}, 16'h0001);
        run(8'h01, 8'h03, 16'h0114, 16'h0001, 1'b0, 8'h00);
    endtask

    task automatic print_verdict();
        if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_normal();
        t_errors();
        t_state();
        t_password();
        print_verdict();
    end
endmodule // modbus_slave_scale_and_exceptions_bench
